// File: core/swl_core.sv
// Purpose: Address table learning, aging, destination resolution and storm limiting.
// Assumes: The MAC receive paths deliver one frame descriptor per FRM_VALID pulse.
// Notes: Lookup is a linear scan, one entry per cycle.
//
// The Wishbone register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module swl_core
   import swl_pkg::*;
#(
   parameter int STORM_CYC_FAST = STORM_CYC_100,
   parameter int STORM_CYC_SLOW = STORM_CYC_10,
   parameter int AGE_CYC = AGE_TICK_CYC
) (
   input wire logic CORE_CLK,
   input wire logic RESET,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [7:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O,
   input wire logic FRM_VALID,
   input wire swl_frame_type FRM,
   input wire logic [4:0] ACL_HIT,
   input wire logic [4:0] ACL_SET,
   input wire logic [4:0] STATIC_HIT,
   input wire logic [4:0] STATIC_SET,
   input wire logic [4:0] VLAN_MEMBER,
   input wire logic [4:0] CELL_FREE,
   output logic FRM_READY,
   output logic FWD_VALID,
   output logic [4:0] FWD_PORTS,
   output logic FWD_DROP,
   output logic PAUSE_SEEN,
   output logic [2:0] PAUSE_PORT
);
   // ****************************************
   // Helper functions
   // ****************************************
   function automatic logic is_mcast(input logic [47:0] a);
      return a[40];
   endfunction : is_mcast

   function automatic logic storm_frame(input logic [47:0] a, input logic mc_en);
      return (a == 48'hffffffffffff) || (mc_en && is_mcast(a));
   endfunction : storm_frame

   function automatic logic [4:0] port_bit(input logic [2:0] p);
      return (p < 3'(NPORT)) ? 5'(5'h01 << p) : 5'h00;
   endfunction : port_bit

   // ****************************************
   // Configuration and working state
   // ****************************************
   swl_entry_type tbl [TBL_DEPTH];
   logic full_q;
   logic [NPORT-1:0] storm_qual;
   logic [7:0] ctrl_q, storm_lo_q, storm_hi_q;
   logic [4:0] port_en_q, speed_q, fwd_mask_q;
   logic [10:0] maxlen_q;
   logic [31:0] wb_dat_q;
   logic wb_ack_q;
   swl_state_type st_q;
   swl_frame_type frm_q;
   logic [TBL_AW-1:0] idx_q, hit_idx_q, sa_idx_q, age_idx_q, fill_q;
   logic [10:0] count_q;
   logic sa_hit_q, da_hit_q;
   logic [2:0] da_port_q;
   logic [4:0] ports_q;
   logic drop_q, valid_q, ready_q, pause_q;
   logic [2:0] pause_port_q;
   logic [31:0] age_cnt_q;
   logic [2:0] now_q;
   logic age_tick;
   logic [31:0] storm_cnt_q [NPORT];
   logic [15:0] storm_bytes_q [NPORT];
   logic [9:0] cells_used_q;
   logic wb_req;
   logic good;
   logic [15:0] thr;
   logic [4:0] prelim, final_set;
   logic storm_drop;

   assign wb_req = WB_CYC_I && WB_STB_I && !wb_ack_q && !WB_ACK_O;
   assign thr = {storm_hi_q, storm_lo_q};
   // ****************************************
   // Register bus
   // ****************************************
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         ctrl_q <= CTRL_RST;
         storm_lo_q <= STORM_LO_RST;
         storm_hi_q <= STORM_HI_RST;
         port_en_q <= 5'h00;
         speed_q <= 5'h1f;
         maxlen_q <= MAXLEN_RST;
         fwd_mask_q <= 5'h1f;
      end else if (wb_req && WB_WE_I && WB_SEL_I[0]) begin
         case (WB_ADR_I)
            REG_CTRL: ctrl_q <= WB_DAT_I[7:0];
            REG_STORM_LO: storm_lo_q <= WB_DAT_I[7:0];
            REG_STORM_HI: storm_hi_q <= WB_DAT_I[7:0];
            REG_PORT_EN: port_en_q <= WB_DAT_I[4:0];
            REG_SPEED: speed_q <= WB_DAT_I[4:0];
            REG_MAXLEN: begin
               if (WB_SEL_I[1]) begin
                  maxlen_q <= (WB_DAT_I[10:0] > 11'(MAX_LEN_LIMIT)) ?
                     11'(MAX_LEN_LIMIT) : WB_DAT_I[10:0];
               end
            end
            REG_FWD_MASK: fwd_mask_q <= WB_DAT_I[4:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         wb_ack_q <= 1'b0;
         wb_dat_q <= 32'h0;
      end else begin
         wb_ack_q <= wb_req;
         if (wb_req && !WB_WE_I) begin
            case (WB_ADR_I)
               REG_CTRL: wb_dat_q <= {24'h0, ctrl_q};
               REG_STORM_LO: wb_dat_q <= {24'h0, storm_lo_q};
               REG_STORM_HI: wb_dat_q <= {24'h0, storm_hi_q};
               REG_PORT_EN: wb_dat_q <= {27'h0, port_en_q};
               REG_SPEED: wb_dat_q <= {27'h0, speed_q};
               REG_MAXLEN: wb_dat_q <= {21'h0, maxlen_q};
               REG_FWD_MASK: wb_dat_q <= {27'h0, fwd_mask_q};
               REG_STATUS: wb_dat_q <= {21'h0, full_q, fill_q};
               REG_FREE: wb_dat_q <= {21'h0, 11'(BUF_CELLS) - {1'b0, cells_used_q}};
               default: wb_dat_q <= 32'h0;
            endcase
         end
      end
   end

   // ****************************************
   // Aging timer
   // ****************************************
   assign age_tick = (age_cnt_q == 32'(AGE_CYC - 1));
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         age_cnt_q <= 32'h0;
         now_q <= 3'h0;
      end else if (age_tick) begin
         age_cnt_q <= 32'h0;
         now_q <= now_q + 3'h1;
      end else begin
         age_cnt_q <= age_cnt_q + 32'h1;
      end
   end

   // ****************************************
   // Storm limiter
   // ****************************************
   assign storm_drop = FRM_VALID && ready_q && port_bit(FRM.port) != 5'h0 &&
      port_en_q[FRM.port] && storm_frame(FRM.da, ctrl_q[CTRL_MCAST_BIT]) &&
      storm_bytes_q[FRM.port] >= thr;
   for (genvar p = 0; p < NPORT; p++) begin : g_storm
      assign storm_qual[p] = FRM_VALID && ready_q && FRM.port == 3'(p) && port_en_q[p] &&
         storm_frame(FRM.da, ctrl_q[CTRL_MCAST_BIT]);
      always_ff @(posedge CORE_CLK or posedge RESET) begin
         if (RESET) begin
            storm_cnt_q[p] <= 32'h0;
            storm_bytes_q[p] <= 16'h0;
         end else if (storm_cnt_q[p] >= 32'(speed_q[p] ? STORM_CYC_FAST - 1 :
            STORM_CYC_SLOW - 1)) begin
            storm_cnt_q[p] <= 32'h0;
            storm_bytes_q[p] <= storm_qual[p] ? 16'(FRM.len) : 16'h0;
         end else begin
            storm_cnt_q[p] <= storm_cnt_q[p] + 32'h1;
            if (storm_qual[p] && storm_bytes_q[p] < 16'hffff - 16'(FRM.len)) begin
               storm_bytes_q[p] <= storm_bytes_q[p] + 16'(FRM.len);
            end
         end
      end
   end

   // ****************************************
   // Shared buffer pool accounting
   // ****************************************
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         cells_used_q <= 10'h0;
      end else if (FRM_VALID && ready_q) begin
         cells_used_q <= cells_used_q + 10'((FRM.len + 11'(BUF_BYTES - 1)) >> 7)
            - 10'($countones(CELL_FREE));
      end else begin
         cells_used_q <= cells_used_q - 10'($countones(CELL_FREE));
      end
   end

   // ****************************************
   // Lookup, learning and forwarding
   // ****************************************
   assign good = !frm_q.err && frm_q.len >= 11'(MIN_LEN) && frm_q.len <= maxlen_q;
   always_comb begin
      prelim = 5'h1f & ~port_bit(frm_q.port);
      if (STATIC_HIT != 5'h0) begin
         prelim = STATIC_SET;
      end else if (da_hit_q && !is_mcast(frm_q.da)) begin
         prelim = port_bit(da_port_q);
      end
      final_set = prelim & VLAN_MEMBER & fwd_mask_q & ~port_bit(frm_q.port);
      if (ACL_HIT != 5'h0) begin
         final_set = ACL_SET;
      end
   end

   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         st_q <= ST_IDLE;
         frm_q <= '0;
         idx_q <= '0;
         count_q <= 11'h0;
         sa_hit_q <= 1'b0;
         da_hit_q <= 1'b0;
         sa_idx_q <= '0;
         da_port_q <= 3'h0;
         ready_q <= 1'b1;
         valid_q <= 1'b0;
         ports_q <= 5'h0;
         drop_q <= 1'b0;
         pause_q <= 1'b0;
         pause_port_q <= 3'h0;
      end else begin
         valid_q <= 1'b0;
         pause_q <= 1'b0;
         case (st_q)
            ST_IDLE: begin
               if (FRM_VALID && ready_q) begin
                  frm_q <= FRM;
                  idx_q <= '0;
                  count_q <= 11'h0;
                  sa_hit_q <= 1'b0;
                  da_hit_q <= 1'b0;
                  ready_q <= 1'b0;
                  drop_q <= storm_drop;
                  st_q <= ST_SEARCH;
               end
            end
            ST_SEARCH: begin
               if (tbl[idx_q].valid && tbl[idx_q].mac == frm_q.sa) begin
                  sa_hit_q <= 1'b1;
                  sa_idx_q <= idx_q;
               end
               if (tbl[idx_q].valid && tbl[idx_q].mac == frm_q.da) begin
                  da_hit_q <= 1'b1;
                  da_port_q <= tbl[idx_q].port;
               end
               count_q <= count_q + 11'h1;
               idx_q <= idx_q + 10'h1;
               if (count_q == 11'(TBL_DEPTH - 1)) begin
                  st_q <= ST_DECIDE;
               end
            end
            ST_DECIDE: begin
               valid_q <= 1'b1;
               ports_q <= final_set;
               if (frm_q.da == PAUSE_DA || frm_q.etype == PAUSE_TYPE) begin
                  ports_q <= 5'h0;
                  pause_q <= good;
                  pause_port_q <= frm_q.port;
                  drop_q <= 1'b1;
               end else if (!good || (da_hit_q && da_port_q == frm_q.port &&
                  ACL_HIT == 5'h0)) begin
                  ports_q <= 5'h0;
                  drop_q <= 1'b1;
               end else if (drop_q) begin
                  ports_q <= 5'h0;
               end else begin
                  drop_q <= final_set == 5'h0;
               end
               st_q <= ST_OUT;
            end
            ST_OUT: begin
               ready_q <= 1'b1;
               st_q <= ST_IDLE;
            end
            default: st_q <= ST_IDLE;
         endcase
      end
   end

   // ****************************************
   // Table writes: learning, migration, refresh and aging
   // ****************************************
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         fill_q <= '0;
         full_q <= 1'b0;
         age_idx_q <= '0;
         for (int i = 0; i < TBL_DEPTH; i++) begin
            tbl[i] <= '0;
         end
      end else begin
         if (st_q == ST_DECIDE && good && !is_mcast(frm_q.sa)) begin
            if (sa_hit_q) begin
               tbl[sa_idx_q].port <= frm_q.port;
               tbl[sa_idx_q].stamp <= now_q;
            end else begin
               tbl[fill_q] <= '{valid: 1'b1, mac: frm_q.sa, port: frm_q.port,
                  stamp: now_q};
               if (fill_q != 10'(TBL_DEPTH - 1)) begin
                  fill_q <= fill_q + 10'h1;
               end else begin
                  full_q <= 1'b1;
               end
            end
         end else if (st_q != ST_SEARCH) begin
            age_idx_q <= age_idx_q + 10'h1;
            if (ctrl_q[CTRL_AGE_BIT] && tbl[age_idx_q].valid &&
               (now_q - tbl[age_idx_q].stamp) >= 3'(AGE_TICKS)) begin
               tbl[age_idx_q].valid <= 1'b0;
            end
         end
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         WB_DAT_O <= 32'h0;
         WB_ACK_O <= 1'b0;
         FRM_READY <= 1'b0;
         FWD_VALID <= 1'b0;
         FWD_PORTS <= 5'h0;
         FWD_DROP <= 1'b0;
         PAUSE_SEEN <= 1'b0;
         PAUSE_PORT <= 3'h0;
      end else begin
         WB_DAT_O <= wb_dat_q;
         WB_ACK_O <= wb_ack_q;
         FRM_READY <= ready_q && !FRM_VALID;
         FWD_VALID <= valid_q;
         FWD_PORTS <= ports_q;
         FWD_DROP <= drop_q;
         PAUSE_SEEN <= pause_q;
         PAUSE_PORT <= pause_port_q;
      end
   end
endmodule : swl_core

// File: core/swl_pkg.sv
// Purpose: Shared constants and types for the switch address learning and forwarding core.
// Assumes: 40 MHz core clock, five ports, classic Wishbone register access.
// Notes: Long interval counts are scaled by top-level parameters.
package swl_pkg;
   localparam int NPORT = 5;
   localparam int TBL_DEPTH = 1024;
   localparam int TBL_AW = 10;
   localparam int BUF_CELLS = 512;
   localparam int BUF_BYTES = 128;
   localparam int CLK_HZ = 40000000;
   localparam int STORM_MS_100 = 50;
   localparam int STORM_MS_10 = 500;
   localparam int STORM_CYC_100 = CLK_HZ / 1000 * STORM_MS_100;
   localparam int STORM_CYC_10 = CLK_HZ / 1000 * STORM_MS_10;
   localparam int AGE_SEC = 300;
   localparam int AGE_TOL_SEC = 75;
   localparam int AGE_TICK_SEC = AGE_TOL_SEC;
   localparam int AGE_TICK_CYC = CLK_HZ * AGE_TICK_SEC;
   localparam int AGE_TICKS = AGE_SEC / AGE_TICK_SEC;
   localparam int MIN_LEN = 64;
   localparam int MAX_LEN_LIMIT = 1536;
   // Register word offsets (byte addresses).
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STORM_LO = 8'h04;
   localparam logic [7:0] REG_STORM_HI = 8'h08;
   localparam logic [7:0] REG_PORT_EN = 8'h0c;
   localparam logic [7:0] REG_SPEED = 8'h10;
   localparam logic [7:0] REG_MAXLEN = 8'h14;
   localparam logic [7:0] REG_FWD_MASK = 8'h18;
   localparam logic [7:0] REG_STATUS = 8'h1c;
   localparam logic [7:0] REG_FREE = 8'h20;
   // Control field positions and resets.
   localparam int CTRL_MCAST_BIT = 0;
   localparam int CTRL_AGE_BIT = 2;
   localparam logic [7:0] CTRL_RST = 8'h04;
   localparam logic [7:0] STORM_LO_RST = 8'h4a;
   localparam logic [7:0] STORM_HI_RST = 8'h00;
   localparam logic [10:0] MAXLEN_RST = 11'h600;
   localparam logic [47:0] PAUSE_DA = 48'h0180c2000001;
   localparam logic [15:0] PAUSE_TYPE = 16'h8808;

   typedef struct packed {
      logic [47:0] da;
      logic [47:0] sa;
      logic [11:0] vid;
      logic [15:0] etype;
      logic [2:0] port;
      logic [10:0] len;
      logic err;
   } swl_frame_type;

   typedef struct packed {
      logic valid;
      logic [47:0] mac;
      logic [2:0] port;
      logic [2:0] stamp;
   } swl_entry_type;

   typedef enum {ST_IDLE, ST_SEARCH, ST_DECIDE, ST_OUT} swl_state_type;
endpackage : swl_pkg

// File: dv/swl_checker.sv
// Purpose: Port checks for swl_core.
// Assumes: A frame is taken while FRM_READY is high.
// Notes: Bound to every swl_core instance.
`timescale 1ns/1ps
module swl_checker
   import swl_pkg::*;
(
   input wire logic CORE_CLK,
   input wire logic RESET,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_ACK_O,
   input wire logic FRM_VALID,
   input wire swl_frame_type FRM,
   input wire logic [4:0] ACL_HIT,
   input wire logic [4:0] ACL_SET,
   input wire logic FRM_READY,
   input wire logic FWD_VALID,
   input wire logic [4:0] FWD_PORTS,
   input wire logic FWD_DROP,
   input wire logic PAUSE_SEEN,
   input wire logic [2:0] PAUSE_PORT
);
   // ****
   // Frame age, ingress port and error state.
   // ****
   logic [10:0] age_q;
   logic [2:0] port_q;
   logic bad_q;
   wire take = FRM_VALID && FRM_READY;
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         age_q <= 11'h000;
         port_q <= 3'h0;
         bad_q <= 1'b0;
      end else if (take) begin
         age_q <= 11'h001;
         port_q <= FRM.port;
         bad_q <= FRM.err || FRM.len < MIN_LEN;
      end else if (FWD_VALID) begin
         age_q <= 11'h000;
      end else if (age_q != 11'h000 && age_q != 11'h7ff) begin
         age_q <= age_q + 11'h001;
      end
   end
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RESET);
   a_ack_two_cycles: assert property ($rose(WB_STB_I) && WB_CYC_I |->
      !WB_ACK_O ##1 !WB_ACK_O ##1 WB_ACK_O) else $error("ack not two cycles after request");
   a_ack_one_cycle: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack longer than one cycle");
   a_ack_needs_req: assert property (WB_ACK_O |-> WB_CYC_I && WB_STB_I) else $error("ack without request");
   a_fwd_pulse: assert property (FWD_VALID |=> !FWD_VALID) else $error("decision longer than one cycle");
   a_fwd_latency: assert property (FWD_VALID |-> age_q >= 11'h402 && age_q <= 11'h404)
      else $error("decision latency wrong");
   a_ready_while_busy: assert property (age_q >= 11'h003 && age_q <= 11'h401 |-> !FRM_READY)
      else $error("ready while busy");
   a_error_not_fwd: assert property (FWD_VALID && bad_q |-> FWD_DROP)
      else $error("bad frame forwarded");
   a_local_excluded: assert property (FWD_VALID && !FWD_DROP && ACL_HIT == 5'h00 |->
      !FWD_PORTS[port_q]) else $error("frame sent back to ingress port");
   a_acl_override: assert property (FWD_VALID && ACL_HIT != 5'h00 && !bad_q && !PAUSE_SEEN |->
      FWD_PORTS == ACL_SET) else $error("override set not used");
   a_pause_consumed: assert property (PAUSE_SEEN |-> FWD_VALID && FWD_PORTS == 5'h00 &&
      PAUSE_PORT == port_q) else $error("pause frame forwarded");
   c_drop: cover property (FWD_VALID && FWD_DROP);
   c_pause: cover property (PAUSE_SEEN);
   c_acl: cover property (FWD_VALID && ACL_HIT != 5'h00);
endmodule : swl_checker
bind swl_core swl_checker swl_checker_i (.CORE_CLK(CORE_CLK), .RESET(RESET), .WB_CYC_I(WB_CYC_I),
   .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O), .FRM_VALID(FRM_VALID), .FRM(FRM), .ACL_HIT(ACL_HIT),
   .ACL_SET(ACL_SET), .FRM_READY(FRM_READY), .FWD_VALID(FWD_VALID), .FWD_PORTS(FWD_PORTS),
   .FWD_DROP(FWD_DROP), .PAUSE_SEEN(PAUSE_SEEN), .PAUSE_PORT(PAUSE_PORT));

// File: dv/swl_mac_model.sv
// Purpose: Receive path model feeding descriptors to swl_core.
// Assumes: The bench holds go high until taken rises.
// Notes: Outside the valid cycle the descriptor toggles.
`timescale 1ns/1ps
module swl_mac_model
   import swl_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic go,
   input wire swl_frame_type desc,
   input wire logic rdy,
   output logic valid,
   output swl_frame_type frm,
   output logic taken
);
   // ****
   // One descriptor per frame, only while ready.
   // ****
   wire send = go && rdy && !taken;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         valid <= 1'b0;
         frm <= '0;
         taken <= 1'b0;
      end else begin
         valid <= send;
         frm <= send ? desc : ~frm;
         taken <= go && (taken || send);
      end
   end
endmodule : swl_mac_model

// File: dv/tb_top.sv
// Purpose: Self-checking bench for swl_core.
// Assumes: Short storm and aging counts set by parameters.
// Notes: Frames enter through swl_mac_model.
`timescale 1ns/1ps
module tb_top
   import swl_pkg::*;
;
   // ****
   // Signals and instances.
   // ****
   localparam int SF = 8000;
   localparam logic [47:0] A = 48'h020000aa0001;
   localparam logic [47:0] C = 48'h020000aa0003;
   localparam logic [47:0] B = 48'hffffffffffff;
   localparam logic [47:0] U = 48'h020000bb0001;
   localparam logic [47:0] M = 48'h01005e000001;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, go = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] dw = 32'h0;
   logic [31:0] dr;
   logic [4:0] acl_hit = 5'h00, acl_set = 5'h00, st_hit = 5'h00, st_set = 5'h00;
   logic [4:0] vlan = 5'h1f;
   logic [4:0] cf = 5'h00;
   logic [4:0] fwd_p;
   logic [2:0] pp;
   logic ack, fv, rdy, taken, fwd_v, fwd_d, ps;
   swl_frame_type desc = '0;
   swl_frame_type frm;
   logic [31:0] rv [10] = '{32'h4, 32'h4a, 32'h0, 32'h0, 32'h1f, 32'h600, 32'h1f, 32'h0,
      32'h200, 32'h0};
   int mismatches = 0, compares = 0, cyc_n = 0;
   always #12.5 clk = ~clk;
   always @(posedge clk) cyc_n <= cyc_n + 1;
   swl_core #(.STORM_CYC_FAST(SF), .STORM_CYC_SLOW(2 * SF), .AGE_CYC(2000)) swl_core_i (
      .CORE_CLK(clk), .RESET(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
      .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(dw), .WB_DAT_O(dr), .WB_ACK_O(ack),
      .FRM_VALID(fv), .FRM(frm), .ACL_HIT(acl_hit), .ACL_SET(acl_set), .STATIC_HIT(st_hit),
      .STATIC_SET(st_set), .VLAN_MEMBER(vlan), .CELL_FREE(cf), .FRM_READY(rdy),
      .FWD_VALID(fwd_v), .FWD_PORTS(fwd_p), .FWD_DROP(fwd_d), .PAUSE_SEEN(ps), .PAUSE_PORT(pp));
   swl_mac_model swl_mac_model_i (.clk(clk), .rst(rst), .go(go), .desc(desc), .rdy(rdy),
      .valid(fv), .frm(frm), .taken(taken));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [31:0] e);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dw <= d;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (n >= 20) mismatches++;
      if (!w) chk(dr, e);
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask : wb
   task automatic fr(input logic [47:0] da, input logic [7:0] s, input logic [2:0] p,
      input logic [10:0] len, input logic err, input logic [5:0] e);
      int n;
      n = 0;
      @(posedge clk);
      desc <= '{da: da, sa: {40'h020000aa00, s}, vid: 12'h001, etype: 16'h0800,
         port: p, len: len, err: err};
      go <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (taken !== 1'b1 && n < 2000);
      go <= 1'b0;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (fwd_v !== 1'b1 && n < 1200);
      if (n >= 1200) mismatches++;
      chk({26'h0, fwd_d, e[5] ? 5'h00 : fwd_p}, {26'h0, e});
      if (da == PAUSE_DA) chk({28'h0, ps, pp}, {28'h0, 1'b1, p});
   endtask : fr
   task automatic finish_test();
      if (mismatches == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : finish_test
   initial begin
      repeat (90000) @(posedge clk);
      mismatches++;
      finish_test();
   end
   // ****
   // Test sequence.
   // ****
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      wb(1'b1, 8'h24, 32'h5a, 32'h0);
      wb(1'b1, REG_FREE, 32'h0, 32'h0);
      wb(1'b1, REG_STORM_HI, 32'h1, 32'h0);
      wb(1'b0, REG_STORM_HI, 32'h0, 32'h1);
      wb(1'b1, REG_STORM_HI, 32'h0, 32'h0);
      for (int i = 0; i < 10; i++) wb(1'b0, 8'(4 * i), 32'h0, rv[i]);
      wb(1'b1, REG_CTRL, 32'h0, 32'h0);
      fr(U, 8'h01, 3'h1, 11'h040, 1'b0, 6'h1d);
      fr(A, 8'h02, 3'h2, 11'h040, 1'b0, 6'h02);
      fr(A, 8'h04, 3'h1, 11'h040, 1'b0, 6'h20);
      fr(U, 8'h01, 3'h3, 11'h040, 1'b0, 6'h17);
      fr(A, 8'h05, 3'h0, 11'h040, 1'b0, 6'h08);
      fr(B, 8'h03, 3'h4, 11'h040, 1'b1, 6'h20);
      fr(C, 8'h06, 3'h0, 11'h040, 1'b0, 6'h1e);
      fr(B, 8'h07, 3'h4, 11'h03f, 1'b0, 6'h20);
      fr(PAUSE_DA, 8'h08, 3'h2, 11'h040, 1'b0, 6'h20);
      vlan <= 5'h0c;
      fr(U, 8'h09, 3'h0, 11'h040, 1'b0, 6'h0c);
      vlan <= 5'h1f;
      st_hit <= 5'h01;
      st_set <= 5'h10;
      fr(U, 8'h0a, 3'h0, 11'h040, 1'b0, 6'h10);
      st_hit <= 5'h00;
      acl_hit <= 5'h01;
      acl_set <= 5'h04;
      fr(U, 8'h0b, 3'h0, 11'h040, 1'b0, 6'h04);
      acl_hit <= 5'h00;
      repeat (12000) @(posedge clk);
      fr(A, 8'h0e, 3'h0, 11'h040, 1'b0, 6'h08);
      wb(1'b1, REG_CTRL, 32'h4, 32'h0);
      repeat (12000) @(posedge clk);
      fr(A, 8'h0e, 3'h0, 11'h040, 1'b0, 6'h1e);
      wb(1'b1, REG_PORT_EN, 32'h1, 32'h0);
      wb(1'b1, REG_STORM_LO, 32'h40, 32'h0);
      while (cyc_n % SF != 40) @(posedge clk);
      fr(B, 8'h0c, 3'h0, 11'h040, 1'b0, 6'h1e);
      fr(B, 8'h0c, 3'h0, 11'h040, 1'b0, 6'h20);
      fr(B, 8'h0d, 3'h1, 11'h040, 1'b0, 6'h1d);
      fr(M, 8'h0c, 3'h0, 11'h040, 1'b0, 6'h1e);
      wb(1'b1, REG_CTRL, 32'h5, 32'h0);
      fr(M, 8'h0c, 3'h0, 11'h040, 1'b0, 6'h20);
      while (cyc_n % SF != 40) @(posedge clk);
      fr(B, 8'h0c, 3'h0, 11'h040, 1'b0, 6'h1e);
      wb(1'b1, REG_SPEED, 32'h0, 32'h0);
      fr(B, 8'h0c, 3'h0, 11'h040, 1'b0, 6'h20);
      repeat (6500) @(posedge clk);
      fr(B, 8'h0c, 3'h0, 11'h040, 1'b0, 6'h20);
      cf <= 5'h03;
      @(posedge clk);
      cf <= 5'h00;
      wb(1'b0, REG_FREE, 32'h0, 32'h1ec);
      finish_test();
   end
endmodule : tb_top
